//--- design/cpsu_core.sv
// cpu status register, interrupt flags, reset cause, program counter and return stack
// assumes instruction decode outside drives one-cycle strobes on SYS_CLK
// Function
// - flag-affecting op blocks data write to flags
// - clear of status clears bank bits, sets zero
// - bank bit zero selects upper data bank
// - timeout flag set by clear/sleep, cleared on expiry
// - power-down flag set by clear, cleared by sleep
// - zero flag follows zero result
// - digit carry from bit three, borrow inverted
// - carry from top bit, not-borrow on subtract
// - rotates load carry with bit shifted out
// - timer overflow flag sets regardless of enables
// - peripheral flags set regardless of enables
// - peripheral enables need peripheral master enable
// - power-on cause flag cleared by reset or by software write
// - low voltage clears software-set voltage flag
// - thirteen-bit counter, only low byte accessible
// - counter reloads take upper bits from latch
// - call/goto page from latch bit three, ignore four
// - eight deep thirteen-bit hidden return stack
// - push on call/interrupt, pop on returns
// - stack wraps circularly, no overflow status
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module cpsu_core #(
    parameter int DEPTH = cpsu_pkg::STK_DEPTH
) (
    // clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RSTN,
    // file-register port
    input  wire logic [7:0]             ADDR,
    input  wire logic [7:0]             WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [7:0]             RDATA,
    // alu operation
    input  wire logic                   ALU_EN,
    input  wire cpsu_pkg::cpsu_alu_op_t ALU_OP,
    input  wire logic [7:0]             ALU_A,
    input  wire logic [7:0]             ALU_B,
    input  wire logic                   ALU_TO_STATUS,
    output logic      [7:0]             ALU_RESULT,
    // direct addressing
    input  wire logic [6:0]             DIR_FIELD,
    output logic      [7:0]             DIR_ADDR,
    // power and watchdog events
    input  wire logic                   WDT_CLR,
    input  wire logic                   SLEEP,
    input  wire logic                   WDT_TIMEOUT,
    input  wire logic                   LV_DETECT,
    // interrupt sources and request
    input  wire logic                   TMR_OVF,
    input  wire logic [7:0]             PERIPH_EVT,
    output logic                        INT_REQ,
    // program flow
    input  wire logic                   STEP,
    input  wire logic                   CALL,
    input  wire logic                   GOTO,
    input  wire logic [10:0]            TARGET,
    input  wire logic                   RET,
    input  wire logic                   INT_ACK,
    output logic      [12:0]            PC
);

    typedef struct packed {
        logic [7:0]             status;
        logic [7:0]             option;
        logic [7:0]             interrupt_control_reg;
        logic [7:0]             pie;
        logic [7:0]             pir;
        logic [1:0]             reset_cause_reg;
        logic [4:0]             latch;
        logic [12:0]            pc;
        logic [DEPTH-1:0][12:0] stack;
        logic [2:0]             sp;
        logic [7:0]             result;
        logic [7:0]             rdata;
        logic [2:0]             lv_sync;
    } cpsu_state_t;

    localparam cpsu_state_t ST_RST = '{
        status:  cpsu_pkg::STATUS_RST,
        option:  cpsu_pkg::OPTION_RST,
        interrupt_control_reg:  cpsu_pkg::INTERRUPT_CONTROL_REG_RST,
        pie:     cpsu_pkg::PIE_RST,
        pir:     cpsu_pkg::PIR_RST,
        reset_cause_reg:    cpsu_pkg::RESET_CAUSE_REG_RST,
        latch:   cpsu_pkg::LATCH_RST,
        pc:      cpsu_pkg::PC_RST,
        default: '0
    };

    cpsu_state_t q;
    cpsu_state_t d;

    // result bits 10:8 are carry, digit carry, zero; 7:0 the data
    function automatic logic [10:0] alu_eval(input cpsu_pkg::cpsu_alu_op_t op,
                                             input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic cin);
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] res;
        logic       c;
        logic       dc;
        sum = 9'h000;
        nib = 5'h00;
        res = 8'h00;
        c   = cin;
        dc  = 1'b0;
        unique case (op)
            cpsu_pkg::ALU_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            end
            cpsu_pkg::ALU_SUB: begin
                sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
                nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
            end
            default: begin
                sum = 9'h000;
                nib = 5'h00;
            end
        endcase
        unique case (op)
            cpsu_pkg::ALU_ADD,
            cpsu_pkg::ALU_SUB: begin
                res = sum[7:0];
                c   = sum[8];
                dc  = nib[4];
            end
            cpsu_pkg::ALU_AND:  res = a & b;
            cpsu_pkg::ALU_IOR:  res = a | b;
            cpsu_pkg::ALU_XOR:  res = a ^ b;
            cpsu_pkg::ALU_CLR:  res = 8'h00;
            cpsu_pkg::ALU_RLF: begin
                res = {a[6:0], cin};
                c   = a[7];
            end
            cpsu_pkg::ALU_RRF: begin
                res = {cin, a[7:1]};
                c   = a[0];
            end
            cpsu_pkg::ALU_MOV:  res = b;
            cpsu_pkg::ALU_SWAP: res = {a[3:0], a[7:4]};
        endcase
        return {c, dc, (res == 8'h00), res};
    endfunction

    // which of carry, digit carry, zero an op updates
    function automatic logic [2:0] alu_mask(input cpsu_pkg::cpsu_alu_op_t op);
        unique case (op)
            cpsu_pkg::ALU_ADD,
            cpsu_pkg::ALU_SUB:  return 3'h7;
            cpsu_pkg::ALU_AND,
            cpsu_pkg::ALU_IOR,
            cpsu_pkg::ALU_XOR,
            cpsu_pkg::ALU_CLR:  return 3'h1;
            cpsu_pkg::ALU_RLF,
            cpsu_pkg::ALU_RRF:  return 3'h4;
            default:            return 3'h0;
        endcase
    endfunction

    logic [10:0] alu_r;
    logic [2:0]  alu_m;
    logic        lv_low;

    assign alu_r  = alu_eval(ALU_OP, ALU_A, ALU_B, q.status[cpsu_pkg::ST_C]);
    assign alu_m  = alu_mask(ALU_OP);
    // second and third sync stages agree on a low-voltage level
    assign lv_low = q.lv_sync[1] & q.lv_sync[2];

    always_comb begin
        d = q;
        d.rdata   = 8'h00;
        d.lv_sync = {q.lv_sync[1:0], LV_DETECT};

        // software writes
        if (WR) begin
            unique case (ADDR)
                cpsu_pkg::ADDR_STATUS: begin
                    d.status[7:5] = WDATA[7:5];
                    d.status[2:0] = WDATA[2:0];
                end
                cpsu_pkg::ADDR_OPTION: d.option = WDATA;
                cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG: d.interrupt_control_reg = WDATA;
                cpsu_pkg::ADDR_PIE:    d.pie    = WDATA;
                cpsu_pkg::ADDR_PIR:    d.pir    = WDATA;
                cpsu_pkg::ADDR_RESET_CAUSE_REG:   d.reset_cause_reg   = WDATA[1:0];
                cpsu_pkg::ADDR_COUNTER_LATCH_REG: d.latch  = WDATA[4:0];
                cpsu_pkg::ADDR_PCL:    d.pc     = {1'b0, q.latch[3:0], WDATA};
                default: ;
            endcase
        end

        // software reads, data one cycle later
        if (RD) begin
            unique case (ADDR)
                cpsu_pkg::ADDR_STATUS: d.rdata = q.status;
                cpsu_pkg::ADDR_OPTION: d.rdata = q.option;
                cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG: d.rdata = q.interrupt_control_reg;
                cpsu_pkg::ADDR_PIE:    d.rdata = q.pie;
                cpsu_pkg::ADDR_PIR:    d.rdata = q.pir;
                cpsu_pkg::ADDR_RESET_CAUSE_REG:   d.rdata = {6'h00, q.reset_cause_reg};
                cpsu_pkg::ADDR_COUNTER_LATCH_REG: d.rdata = {3'h0, q.latch};
                cpsu_pkg::ADDR_PCL:    d.rdata = q.pc[7:0];
                default:               d.rdata = 8'h00;
            endcase
        end

        // alu result, optionally into status
        if (ALU_EN) begin
            d.result = alu_r[7:0];
            if (ALU_TO_STATUS) begin
                d.status[7:5] = alu_r[7:5];
                if (alu_m == 3'h0) begin
                    d.status[2:0] = alu_r[2:0];
                end
            end
            if (alu_m[2]) begin
                d.status[cpsu_pkg::ST_C] = alu_r[10];
            end
            if (alu_m[1]) begin
                d.status[cpsu_pkg::ST_DC] = alu_r[9];
            end
            if (alu_m[0]) begin
                d.status[cpsu_pkg::ST_Z] = alu_r[8];
            end
        end

        // power and watchdog flags
        if (WDT_CLR) begin
            d.status[cpsu_pkg::ST_TO] = 1'b1;
            d.status[cpsu_pkg::ST_PD] = 1'b1;
        end
        if (SLEEP) begin
            d.status[cpsu_pkg::ST_TO] = 1'b1;
            d.status[cpsu_pkg::ST_PD] = 1'b0;
        end
        if (WDT_TIMEOUT) begin
            d.status[cpsu_pkg::ST_TO] = 1'b0;
        end

        // hardware events win over software writes
        if (TMR_OVF) begin
            d.interrupt_control_reg[cpsu_pkg::IC_TIMER_OVERFLOW_FLAG] = 1'b1;
        end
        d.pir = d.pir | PERIPH_EVT;
        if (lv_low) begin
            d.reset_cause_reg[cpsu_pkg::PC_LVD] = 1'b0;
        end

        // program counter and stack
        if (INT_ACK) begin
            d.stack[q.sp] = q.pc;
            d.sp          = q.sp + 3'h1;
            d.pc          = cpsu_pkg::INT_VECTOR;
        end else if (CALL) begin
            d.stack[q.sp] = q.pc + 13'h0001;
            d.sp          = q.sp + 3'h1;
            d.pc          = {1'b0, q.latch[cpsu_pkg::PAGE_BIT], TARGET};
        end else if (GOTO) begin
            d.pc = {1'b0, q.latch[cpsu_pkg::PAGE_BIT], TARGET};
        end else if (RET) begin
            d.sp = q.sp - 3'h1;
            d.pc = q.stack[q.sp - 3'h1];
        end else if (STEP && !(WR && ADDR == cpsu_pkg::ADDR_PCL)) begin
            d.pc = q.pc + 13'h0001;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign RDATA      = q.rdata;
    assign ALU_RESULT = q.result;
    assign PC         = q.pc;
    assign DIR_ADDR   = {q.status[cpsu_pkg::ST_RP0], DIR_FIELD};
    assign INT_REQ    = q.interrupt_control_reg[cpsu_pkg::IC_GIE] &
                        ((q.interrupt_control_reg[cpsu_pkg::IC_TOIE] & q.interrupt_control_reg[cpsu_pkg::IC_TIMER_OVERFLOW_FLAG]) |
                         (q.interrupt_control_reg[cpsu_pkg::IC_PERIPHERAL_INTERRUPT_ENABLE] & (|(q.pie & q.pir))));

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_clr_status: assert property (
        (ALU_EN && ALU_OP == cpsu_pkg::ALU_CLR && ALU_TO_STATUS && !WDT_CLR && !SLEEP && !WDT_TIMEOUT)
        |=> (q.status[7:5] == 3'h0) && q.status[cpsu_pkg::ST_Z] && $stable(q.status[4:3])
            && $stable(q.status[1:0]))
        else $error("clear of status gave wrong bits");

    a_add_carry: assert property (
        (ALU_EN && ALU_OP == cpsu_pkg::ALU_ADD)
        |=> q.status[cpsu_pkg::ST_C] == (({1'b0, $past(ALU_A)} + {1'b0, $past(ALU_B)}) > 9'h0FF))
        else $error("carry after add is wrong");

    a_sub_digit: assert property (
        (ALU_EN && ALU_OP == cpsu_pkg::ALU_SUB)
        |=> q.status[cpsu_pkg::ST_DC] == ($past(ALU_A[3:0]) >= $past(ALU_B[3:0])))
        else $error("digit borrow after subtract is wrong");

    a_zero_flag: assert property (
        (ALU_EN && ALU_OP == cpsu_pkg::ALU_AND)
        |=> q.status[cpsu_pkg::ST_Z] == (ALU_RESULT == 8'h00))
        else $error("zero flag does not follow result");

    a_sleep_pd: assert property (
        (SLEEP && !WDT_CLR) |=> !q.status[cpsu_pkg::ST_PD] && q.status[cpsu_pkg::ST_TO] == !$past(WDT_TIMEOUT))
        else $error("sleep did not clear power-down flag");

    a_timeout_clr: assert property (
        WDT_TIMEOUT |=> !q.status[cpsu_pkg::ST_TO])
        else $error("watchdog expiry did not clear timeout flag");

    a_timer_flag: assert property (
        TMR_OVF |=> q.interrupt_control_reg[cpsu_pkg::IC_TIMER_OVERFLOW_FLAG])
        else $error("timer overflow flag lost");

    a_periph_flag: assert property (
        (PERIPH_EVT != 8'h00) |=> ((q.pir & $past(PERIPH_EVT)) == $past(PERIPH_EVT)))
        else $error("peripheral flag lost");

    a_periph_gate: assert property (
        (!q.interrupt_control_reg[cpsu_pkg::IC_PERIPHERAL_INTERRUPT_ENABLE] && !(q.interrupt_control_reg[cpsu_pkg::IC_TOIE] && q.interrupt_control_reg[cpsu_pkg::IC_TIMER_OVERFLOW_FLAG]))
        |-> !INT_REQ)
        else $error("interrupt request without peripheral master enable");

    a_call_page: assert property (
        (CALL && !INT_ACK) |=> PC == {1'b0, $past(q.latch[cpsu_pkg::PAGE_BIT]), $past(TARGET)})
        else $error("call target page is wrong");

    a_call_return: assert property (
        (CALL && !INT_ACK) ##1 (RET && !CALL && !GOTO && !INT_ACK)
        |=> PC == $past(PC, 2) + 13'h0001)
        else $error("return did not restore call address");

endmodule

//--- design/cpsu_pkg.sv
// constants for the cpu status, program counter and return stack unit
// assumes one 10 MHz core clock and a plain file-register port
package cpsu_pkg;

    // register offsets on the file-register port
    localparam logic [7:0] ADDR_OPTION = 8'h81;
    localparam logic [7:0] ADDR_PCL    = 8'h82;
    localparam logic [7:0] ADDR_STATUS = 8'h83;
    localparam logic [7:0] ADDR_COUNTER_LATCH_REG = 8'h8A;
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL_REG = 8'h8B;
    localparam logic [7:0] ADDR_PIE    = 8'h8C;
    localparam logic [7:0] ADDR_PIR    = 8'h0C;
    localparam logic [7:0] ADDR_RESET_CAUSE_REG   = 8'h8E;

    // alu_flags_and_bank_select fields
    localparam int ST_IRP = 7;
    localparam int ST_RP1 = 6;
    localparam int ST_RP0 = 5;
    localparam int ST_TO  = 4;
    localparam int ST_PD  = 3;
    localparam int ST_Z   = 2;
    localparam int ST_DC  = 1;
    localparam int ST_C   = 0;

    // interrupt_control_reg fields
    localparam int IC_GIE  = 7;
    localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
    localparam int IC_TOIE = 5;
    localparam int IC_TIMER_OVERFLOW_FLAG = 2;

    // reset_cause_reg fields
    localparam int PC_POR = 1;
    localparam int PC_LVD = 0;

    // reset values
    localparam logic [7:0]  STATUS_RST = 8'h18;
    localparam logic [7:0]  OPTION_RST = 8'hFF;
    localparam logic [7:0]  INTERRUPT_CONTROL_REG_RST = 8'h00;
    localparam logic [7:0]  PIE_RST    = 8'h00;
    localparam logic [7:0]  PIR_RST    = 8'h00;
    localparam logic [1:0]  RESET_CAUSE_REG_RST   = 2'h0;
    localparam logic [4:0]  LATCH_RST  = 5'h00;
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;

    // counter and stack shape
    localparam int PC_W      = 13;
    localparam int STK_DEPTH = 8;
    localparam int PAGE_BIT  = 3;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
        ALU_CLR, ALU_RLF, ALU_RRF, ALU_MOV, ALU_SWAP
    } cpsu_alu_op_t;

endpackage

//--- sim/tb_top.sv
// self-checking bench for the status, counter and return stack unit
// assumes cpsu_pkg and cpsu_core are compiled first; one 10 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp=%h got=%h", nm, e, g); end end

module tb_top;
    logic                  sys_clk   = 1'b0;
    logic                  rstn      = 1'b0;
    logic [7:0]            addr      = 8'h00;
    logic [7:0]            wdata     = 8'h00;
    logic                  wr        = 1'b0;
    logic                  rd        = 1'b0;
    logic [7:0]            rdata;
    logic                  alu_en    = 1'b0;
    cpsu_pkg::cpsu_alu_op_t alu_op   = cpsu_pkg::ALU_ADD;
    logic [7:0]            alu_a     = 8'h00;
    logic [7:0]            alu_b     = 8'h00;
    logic                  alu_to_st = 1'b0;
    logic [7:0]            alu_res;
    logic [6:0]            dir_field = 7'h00;
    logic [7:0]            dir_addr;
    logic                  lv        = 1'b0;
    logic [7:0]            pevt      = 8'h00;
    logic                  int_req;
    logic [10:0]           target    = 11'h000;
    logic [12:0]           pc;
    // 0 wdt clear, 1 sleep, 2 wdt expiry, 3 timer ovf, 4 step, 5 call, 6 goto, 7 ret, 8 int ack
    logic [8:0]            evs       = 9'h000;
    int                    n_fail    = 0;
    int                    checked   = 0;
    logic [7:0]            st        = 8'h18;
    logic [12:0]           pm        = 13'h0000;
    logic [4:0]            lat;
    logic [12:0]           stk [8];
    int                    sp        = 0;
    logic [7:0]            v;
    logic [10:0]           tgt;

    cpsu_core i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ALU_EN(alu_en), .ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b),
        .ALU_TO_STATUS(alu_to_st), .ALU_RESULT(alu_res), .DIR_FIELD(dir_field), .DIR_ADDR(dir_addr),
        .WDT_CLR(evs[0]), .SLEEP(evs[1]), .WDT_TIMEOUT(evs[2]), .LV_DETECT(lv), .TMR_OVF(evs[3]),
        .PERIPH_EVT(pevt), .INT_REQ(int_req), .STEP(evs[4]), .CALL(evs[5]), .GOTO(evs[6]),
        .TARGET(target), .RET(evs[7]), .INT_ACK(evs[8]), .PC(pc));

    always #50 sys_clk = ~sys_clk;

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask

    task automatic ev(input int i, input logic [10:0] t);
        @(posedge sys_clk);
        evs[i] <= 1'b1;
        target <= t;
        @(posedge sys_clk);
        evs <= 9'h000;
        #1;
    endtask

    task automatic alu(input int k, input logic [7:0] a, input logic [7:0] b, input logic ts);
        logic [8:0] s;
        logic [7:0] r;
        logic [2:0] f;
        logic [2:0] m;
        logic [6:0] fld;
        fld = 7'($urandom);
        @(posedge sys_clk);
        alu_en    <= 1'b1;
        alu_op    <= cpsu_pkg::cpsu_alu_op_t'(k);
        alu_a     <= a;
        alu_b     <= b;
        alu_to_st <= ts;
        dir_field <= fld;
        @(posedge sys_clk);
        alu_en <= 1'b0;
        #1;
        s = 9'h000;
        f = 3'h0;
        m = 3'b100;
        case (k)
            0: begin s = a + b; r = s[7:0]; f = {r == 8'h00, (a[3:0] + b[3:0]) > 5'h0F, s[8]}; m = 3'b111; end
            1: begin r = a - b; f = {r == 8'h00, a[3:0] >= b[3:0], a >= b}; m = 3'b111; end
            2: r = a & b;
            3: r = a | b;
            4: r = a ^ b;
            5: r = 8'h00;
            6: begin r = {a[6:0], st[0]}; f[0] = a[7]; m = 3'b001; end
            7: begin r = {st[0], a[7:1]}; f[0] = a[0]; m = 3'b001; end
            8: begin r = b; m = 3'b000; end
            default: begin r = {a[3:0], a[7:4]}; m = 3'b000; end
        endcase
        if (m == 3'b100) f[2] = (r == 8'h00);
        st[2:0] = (st[2:0] & ~m) | (f & m);
        if (ts) begin
            st[7:5] = r[7:5];
            if (m == 3'b000) st[2:0] = r[2:0];
        end
        `CHK("alu_res", r, alu_res)
        rchk(cpsu_pkg::ADDR_STATUS, st);
        `CHK("dir_addr", {st[5], fld}, dir_addr)
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h620C));
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk(cpsu_pkg::ADDR_STATUS, 8'h18);
        @(posedge sys_clk);
        #1;
        `CHK("rdata idle", 8'h00, rdata)
        rchk(cpsu_pkg::ADDR_OPTION, 8'hFF);
        rchk(cpsu_pkg::ADDR_RESET_CAUSE_REG, 8'h00);
        rchk(8'h05, 8'h00);
        wr_reg(cpsu_pkg::ADDR_OPTION, 8'h5A);
        rchk(cpsu_pkg::ADDR_OPTION, 8'h5A);
        // flag corners, then random ops
        alu(0, 8'hFF, 8'h01, 1'b0);
        alu(1, 8'h05, 8'h05, 1'b0);
        alu(1, 8'h00, 8'h01, 1'b0);
        alu(1, 8'h10, 8'h01, 1'b0);
        alu(6, 8'h80, 8'h00, 1'b0);
        alu(7, 8'h01, 8'h00, 1'b0);
        alu(5, 8'h3C, 8'h00, 1'b1);
        for (int k = 0; k < 10; k++) alu(k, 8'($urandom), 8'($urandom), 1'b1);
        for (int n = 0; n < 80; n++) alu($urandom % 10, 8'($urandom), 8'($urandom), ($urandom % 4) == 0);
        // direct writes cannot reach timeout and power-down
        wr_reg(cpsu_pkg::ADDR_STATUS, 8'hFF);
        st = 8'hE7 | (st & 8'h18);
        rchk(cpsu_pkg::ADDR_STATUS, st);
        `CHK("dir_addr", {1'b1, dir_field}, dir_addr)
        wr_reg(cpsu_pkg::ADDR_STATUS, 8'h00);
        st = st & 8'h18;
        `CHK("dir_addr", {1'b0, dir_field}, dir_addr)
        ev(1, 11'h000);
        st[4:3] = 2'b10;
        rchk(cpsu_pkg::ADDR_STATUS, st);
        ev(2, 11'h000);
        st[4] = 1'b0;
        rchk(cpsu_pkg::ADDR_STATUS, st);
        ev(0, 11'h000);
        st[4:3] = 2'b11;
        rchk(cpsu_pkg::ADDR_STATUS, st);
        // interrupt flags and gating
        ev(3, 11'h000);
        rchk(cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG, 8'h04);
        `CHK("int_req", 1'b0, int_req)
        wr_reg(cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG, 8'hA4);
        `CHK("int_req", 1'b1, int_req)
        wr_reg(cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG, 8'h00);
        @(posedge sys_clk);
        pevt <= 8'h05;
        @(posedge sys_clk);
        pevt <= 8'h00;
        rchk(cpsu_pkg::ADDR_PIR, 8'h05);
        wr_reg(cpsu_pkg::ADDR_PIE, 8'h01);
        wr_reg(cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG, 8'h80);
        `CHK("int_req", 1'b0, int_req)
        wr_reg(cpsu_pkg::ADDR_INTERRUPT_CONTROL_REG, 8'hC0);
        `CHK("int_req", 1'b1, int_req)
        // reset cause flags
        wr_reg(cpsu_pkg::ADDR_RESET_CAUSE_REG, 8'h03);
        rchk(cpsu_pkg::ADDR_RESET_CAUSE_REG, 8'h03);
        @(posedge sys_clk);
        lv <= 1'b1;
        repeat (6) @(posedge sys_clk);
        lv <= 1'b0;
        rchk(cpsu_pkg::ADDR_RESET_CAUSE_REG, 8'h02);
        // counter loads, paging and the return stack
        wr_reg(cpsu_pkg::ADDR_COUNTER_LATCH_REG, 8'hFF);
        lat = 5'h1F;
        rchk(cpsu_pkg::ADDR_COUNTER_LATCH_REG, 8'h1F);
        ev(6, 11'h7A5);
        pm = {1'b0, lat[3], 11'h7A5};
        `CHK("pc goto", pm, pc)
        wr_reg(cpsu_pkg::ADDR_PCL, 8'hC3);
        pm = {1'b0, lat[3:0], 8'hC3};
        `CHK("pc pcl", pm, pc)
        rchk(cpsu_pkg::ADDR_PCL, 8'hC3);
        ev(4, 11'h000);
        pm = pm + 13'h0001;
        `CHK("pc step", pm, pc)
        for (int n = 0; n < 10; n++) begin
            v = 8'($urandom);
            wr_reg(cpsu_pkg::ADDR_COUNTER_LATCH_REG, v);
            lat = v[4:0];
            tgt = 11'($urandom);
            stk[sp] = pm + 13'h0001;
            sp = (sp + 1) % 8;
            pm = {1'b0, lat[3], tgt};
            ev(5, tgt);
            `CHK("pc call", pm, pc)
        end
        for (int n = 0; n < 10; n++) begin
            sp = (sp + 7) % 8;
            pm = stk[sp];
            ev(7, 11'h000);
            `CHK("pc ret", pm, pc)
        end
        rchk(cpsu_pkg::ADDR_COUNTER_LATCH_REG, {3'b000, lat});
        stk[sp] = pm;
        sp = (sp + 1) % 8;
        ev(8, 11'h000);
        `CHK("pc vector", cpsu_pkg::INT_VECTOR, pc)
        sp = (sp + 7) % 8;
        ev(7, 11'h000);
        `CHK("pc reti", stk[sp], pc)
        pm = stk[sp];
        // call then return on the very next edge
        @(posedge sys_clk);
        evs[5] <= 1'b1;
        target <= 11'h123;
        @(posedge sys_clk);
        evs    <= 9'h080;
        @(posedge sys_clk);
        evs    <= 9'h000;
        #1;
        `CHK("pc call ret", pm + 13'h0001, pc)
        // second power-on reset clears the cause flags again
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        `CHK("pc reset", 13'h0000, pc)
        rchk(cpsu_pkg::ADDR_RESET_CAUSE_REG, 8'h00);
        rchk(cpsu_pkg::ADDR_STATUS, 8'h18);
        report_and_stop();
    end
endmodule
